// [common/eepi_pkg.sv]
package eepi_pkg;
   // Array and page geometry
   localparam int ADDR_W = 16;
   localparam int PAGE_W = 7;
   localparam int PAGE_BYTES = 128;
   localparam int MEM_BYTES = 65536;
   // Device address byte layout
   localparam int DEV_TYPE_HI = 7;
   localparam int DEV_TYPE_LO = 4;
   localparam int DEV_CS_HI = 3;
   localparam int DEV_CS_LO = 1;
   localparam int DEV_RW = 0;
   localparam logic [3:0] DEV_MAIN = 4'ha;
   // Bit slots within one byte frame
   localparam logic [3:0] BIT_FIRST = 4'h1;
   localparam logic [3:0] BIT_LAST = 4'h7;
   localparam logic [3:0] BIT_ACK = 4'h8;
   // Delivery state of the array
   localparam logic [7:0] ERASED = 8'hff;
   // Programming cycle time
   localparam int CLK_HZ = 20_000_000;
   localparam int T_PROG_US = 5000;
   localparam int PROG_CYC = T_PROG_US * (CLK_HZ / 1_000_000);
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_DEV,
      ST_AHI,
      ST_ALO,
      ST_WDAT,
      ST_RDAT
   } eepi_state_e;
endpackage

// [common/eepi_link_if.sv]
`timescale 1ns/100ps
interface eepi_link_if;
   logic start_tgl;
   logic stop_tgl;
   logic wr_pend;
   logic busy;
   logic commit;
   logic standby;
   modport det (output start_tgl, output stop_tgl);
   modport timer (
      input start_tgl,
      input stop_tgl,
      input wr_pend,
      output busy,
      output commit,
      output standby
   );
   modport core (
      input start_tgl,
      input busy,
      input commit,
      input standby,
      output wr_pend
   );
endinterface

// [core/eepi_cond_det.sv]
`timescale 1ns/100ps
module eepi_cond_det (
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic nrst_i,
   eepi_link_if.det lnk
);
   logic start_tgl_ff;
   logic stop_tgl_ff;

   // Data edges while the clock is high are frame markers, not data
   always_ff @(negedge sda_i or negedge nrst_i) begin
      if (!nrst_i) begin
         start_tgl_ff <= 1'b0;
      end else if (scl_i) begin
         start_tgl_ff <= ~start_tgl_ff;
      end
   end

   always_ff @(posedge sda_i or negedge nrst_i) begin
      if (!nrst_i) begin
         stop_tgl_ff <= 1'b0;
      end else if (scl_i) begin
         stop_tgl_ff <= ~stop_tgl_ff;
      end
   end

   assign lnk.start_tgl = start_tgl_ff;
   assign lnk.stop_tgl = stop_tgl_ff;
endmodule

// [core/eepi_prog_timer.sv]
`timescale 1ns/100ps
module eepi_prog_timer
   import eepi_pkg::*;
#(
   parameter int PROG_CYCLES = PROG_CYC
) (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic ce_i,
   eepi_link_if.timer lnk
);
   localparam int CNT_W = $clog2(PROG_CYCLES + 1);
   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(PROG_CYCLES - 1);

   logic [2:0] start_sy_ff;
   logic [2:0] stop_sy_ff;
   logic [1:0] pend_sy_ff;
   logic [CNT_W-1:0] cnt_ff;
   logic busy_ff;
   logic commit_ff;
   logic standby_ff;

   wire logic start_ev = start_sy_ff[2] ^ start_sy_ff[1];
   wire logic stop_ev = stop_sy_ff[2] ^ stop_sy_ff[1];
   wire logic prog_go = stop_ev && pend_sy_ff[1] && !busy_ff;
   wire logic prog_done = busy_ff && (cnt_ff == CNT_LAST);
   wire logic idle_set = prog_done || (stop_ev && !pend_sy_ff[1] && !busy_ff);
   wire logic idle_clr = start_ev || prog_go;
   wire logic nxt_standby = idle_set ? 1'b1 :
                            (idle_clr ? 1'b0 : standby_ff);
   wire logic [CNT_W-1:0] nxt_cnt = prog_go ? '0 :
                                    CNT_W'(cnt_ff + 1'b1);

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         start_sy_ff <= 3'h0;
         stop_sy_ff <= 3'h0;
         pend_sy_ff <= 2'h0;
         cnt_ff <= '0;
         busy_ff <= 1'b0;
         commit_ff <= 1'b0;
         standby_ff <= 1'b1;
      end else if (ce_i) begin
         start_sy_ff <= {start_sy_ff[1:0], lnk.start_tgl};
         stop_sy_ff <= {stop_sy_ff[1:0], lnk.stop_tgl};
         pend_sy_ff <= {pend_sy_ff[0], lnk.wr_pend};
         cnt_ff <= nxt_cnt;
         busy_ff <= prog_go || (busy_ff && !prog_done);
         commit_ff <= prog_go;
         standby_ff <= nxt_standby;
      end
   end

   assign lnk.busy = busy_ff;
   assign lnk.commit = commit_ff;
   assign lnk.standby = standby_ff;

   AST_PROG_START: assert property (@(posedge clk_i) disable iff (!nrst_i)
      prog_go && ce_i |=> busy_ff && commit_ff)
      else $error("programming did not start at stop");
   AST_PROG_BOUND: assert property (@(posedge clk_i) disable iff (!nrst_i)
      $fell(busy_ff) |-> $past(cnt_ff) == CNT_LAST)
      else $error("programming cycle length wrong");
   AST_IDLE_AFTER: assert property (@(posedge clk_i) disable iff (!nrst_i)
      prog_done && ce_i |=> standby_ff && !busy_ff)
      else $error("no standby after programming");
   COV_PROG_DONE: cover property (@(posedge clk_i) disable iff (!nrst_i)
      prog_done);
endmodule

// [core/eepi_target.sv]
`timescale 1ns/100ps
module eepi_target
   import eepi_pkg::*;
#(
   parameter int PROG_CYCLES = PROG_CYC
) (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic ce_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   input wire logic wp_i,
   input wire logic chip_select_strap_0_i,
   input wire logic chip_select_strap_1_i,
   input wire logic chip_select_strap_2_i,
   output logic busy_o,
   output logic standby_o
);
   localparam int HI_W = ADDR_W - PAGE_W;

   function automatic logic [ADDR_W-1:0] page_inc(
      input logic [ADDR_W-1:0] a
   );
      page_inc = {a[ADDR_W-1:PAGE_W], PAGE_W'(a[PAGE_W-1:0] + 1'b1)};
   endfunction

   eepi_link_if lnk ();

   eepi_cond_det u_det (
      .scl_i(scl_i),
      .sda_i(sda_i),
      .nrst_i(nrst_i),
      .lnk(lnk.det)
   );

   eepi_prog_timer #(
      .PROG_CYCLES(PROG_CYCLES)
   ) u_timer (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .ce_i(ce_i),
      .lnk(lnk.timer)
   );

   eepi_state_e state_ff;
   eepi_state_e nxt_state;
   eepi_state_e go_ff;
   eepi_state_e nxt_go;
   logic [3:0] bit_cnt_ff;
   logic [3:0] nxt_bit_cnt;
   logic [7:0] shift_ff;
   logic [7:0] tx_ff;
   logic [7:0] nxt_tx;
   logic ack_ff;
   logic nxt_ack;
   logic [ADDR_W-1:0] ptr_ff;
   logic [ADDR_W-1:0] nxt_ptr;
   logic [7:0] addr_hi_ff;
   logic start_seen_ff;
   logic [7:0] page_buf_ff [PAGE_BYTES];
   logic [PAGE_BYTES-1:0] page_vld_ff;
   logic [HI_W-1:0] page_base_ff;
   logic wr_pend_ff;
   logic busy_s1_ff;
   logic busy_s2_ff;
   logic wp_s1_ff;
   logic wp_s2_ff;
   logic [2:0] cs_s1_ff;
   logic [2:0] cs_s2_ff;
   logic sda_oe_ff;
   logic sda_lvl_ff;
   logic [7:0] mem_ff [MEM_BYTES];

   // Start toggle flips while the clock is high; protocol timing keeps it
   // settled well before the next rising edge, so it is read directly.
   wire logic start_now = lnk.start_tgl != start_seen_ff;
   wire logic [7:0] rx_byte = {shift_ff[6:0], sda_i};
   wire logic byte_done = (bit_cnt_ff == BIT_LAST) && !start_now;
   wire logic ack_slot = (bit_cnt_ff == BIT_ACK) && !start_now;
   wire logic in_frame = state_ff != ST_IDLE;
   wire logic type_ok =
      rx_byte[DEV_TYPE_HI:DEV_TYPE_LO] == DEV_MAIN;
   // Pads pull floating straps low
   wire logic cs_ok =
      rx_byte[DEV_CS_HI:DEV_CS_LO] == cs_s2_ff;
   wire logic dev_ok = type_ok && cs_ok && !busy_s2_ff;
   wire logic rd_dir = rx_byte[DEV_RW];
   wire logic dev_wr_ok = (state_ff == ST_DEV) && byte_done && dev_ok &&
                          !rd_dir;
   wire logic wr_take = (state_ff == ST_WDAT) && byte_done &&
                        !wp_s2_ff;
   wire logic master_ack = !sda_i;
   wire logic load_rd = ack_slot &&
      (((state_ff == ST_RDAT) && master_ack) ||
       ((state_ff != ST_RDAT) && ack_ff && (go_ff == ST_RDAT)));
   wire logic drive_ack = ack_slot && ack_ff;
   wire logic drive_rd = (state_ff == ST_RDAT) && !ack_slot &&
                         !start_now && !tx_ff[7];
   wire logic [7:0] rd_byte = mem_ff[ptr_ff];

   always_comb begin
      nxt_state = state_ff;
      nxt_go = go_ff;
      nxt_ack = ack_ff;
      nxt_ptr = ptr_ff;
      nxt_tx = {tx_ff[6:0], 1'b0};
      nxt_bit_cnt = 4'(bit_cnt_ff + 1'b1);
      if (start_now) begin
         // Any start restarts the interface, even mid-byte
         nxt_state = ST_DEV;
         nxt_bit_cnt = BIT_FIRST;
         nxt_ack = 1'b0;
      end else if (!in_frame) begin
         nxt_bit_cnt = bit_cnt_ff;
      end else if (byte_done) begin
         nxt_ack = 1'b0;
         case (state_ff)
            ST_DEV: begin
               nxt_ack = dev_ok;
               nxt_go = rd_dir ? ST_RDAT : ST_AHI;
            end
            ST_AHI: begin
               nxt_ack = 1'b1;
               nxt_go = ST_ALO;
            end
            ST_ALO: begin
               nxt_ack = 1'b1;
               nxt_go = ST_WDAT;
               nxt_ptr = {addr_hi_ff, rx_byte};
            end
            ST_WDAT: begin
               nxt_ack = !wp_s2_ff;
               if (wr_take) begin
                  nxt_ptr = page_inc(ptr_ff);
               end
            end
            default: begin
               nxt_ack = 1'b0;
            end
         endcase
      end else if (ack_slot) begin
         nxt_bit_cnt = 4'h0;
         nxt_ack = 1'b0;
         if (load_rd) begin
            nxt_state = ST_RDAT;
            nxt_tx = rd_byte;
            nxt_ptr = ADDR_W'(ptr_ff + 1'b1);
         end else if ((state_ff != ST_RDAT) && ack_ff) begin
            nxt_state = go_ff;
         end else begin
            nxt_state = ST_IDLE;
         end
      end
   end

   // Bus side: sample on rising clock edges
   always_ff @(posedge scl_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state_ff <= ST_IDLE;
         go_ff <= ST_IDLE;
         bit_cnt_ff <= 4'h0;
         shift_ff <= 8'h00;
         tx_ff <= 8'h00;
         ack_ff <= 1'b0;
         ptr_ff <= '0;
         start_seen_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         go_ff <= nxt_go;
         bit_cnt_ff <= nxt_bit_cnt;
         shift_ff <= rx_byte;
         tx_ff <= nxt_tx;
         ack_ff <= nxt_ack;
         ptr_ff <= nxt_ptr;
         start_seen_ff <= lnk.start_tgl;
      end
   end

   always_ff @(posedge scl_i or negedge nrst_i) begin
      if (!nrst_i) begin
         addr_hi_ff <= 8'h00;
      end else if ((state_ff == ST_AHI) && byte_done) begin
         addr_hi_ff <= rx_byte;
      end
   end

   // Pins from outside the bus clock pass two stages
   always_ff @(posedge scl_i or negedge nrst_i) begin
      if (!nrst_i) begin
         busy_s1_ff <= 1'b0;
         busy_s2_ff <= 1'b0;
         wp_s1_ff <= 1'b0;
         wp_s2_ff <= 1'b0;
         cs_s1_ff <= 3'h0;
         cs_s2_ff <= 3'h0;
      end else begin
         busy_s1_ff <= lnk.busy;
         busy_s2_ff <= busy_s1_ff;
         wp_s1_ff <= wp_i;
         wp_s2_ff <= wp_s1_ff;
         cs_s1_ff <= {chip_select_strap_2_i, chip_select_strap_1_i,
                      chip_select_strap_0_i};
         cs_s2_ff <= cs_s1_ff;
      end
   end

   // Page buffer; index wraps so surplus bytes overwrite earlier ones
   always_ff @(posedge scl_i or negedge nrst_i) begin
      if (!nrst_i) begin
         page_vld_ff <= '0;
         page_base_ff <= '0;
      end else if (dev_wr_ok) begin
         page_vld_ff <= '0;
      end else if (wr_take) begin
         page_vld_ff[ptr_ff[PAGE_W-1:0]] <= 1'b1;
         page_base_ff <= ptr_ff[ADDR_W-1:PAGE_W];
      end
   end

   always_ff @(posedge scl_i) begin
      if (wr_take) begin
         page_buf_ff[ptr_ff[PAGE_W-1:0]] <= rx_byte;
      end
   end

   // Cleared on every start so a later stop cannot program twice
   always_ff @(posedge scl_i or negedge nrst_i) begin
      if (!nrst_i) begin
         wr_pend_ff <= 1'b0;
      end else if (start_now) begin
         wr_pend_ff <= 1'b0;
      end else if (wr_take) begin
         wr_pend_ff <= 1'b1;
      end
   end

   assign lnk.wr_pend = wr_pend_ff;

   // Drive side: change the line only while the clock is low
   always_ff @(negedge scl_i or negedge nrst_i) begin
      if (!nrst_i) begin
         sda_oe_ff <= 1'b0;
         sda_lvl_ff <= 1'b0;
      end else begin
         sda_oe_ff <= drive_ack || drive_rd;
         sda_lvl_ff <= 1'b0;
      end
   end

   // Buffer and base are quiet while busy, so the commit reads them safely
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         for (int i = 0; i < MEM_BYTES; i++) begin
            mem_ff[i] <= ERASED;
         end
      end else if (ce_i && lnk.commit) begin
         for (int i = 0; i < PAGE_BYTES; i++) begin
            if (page_vld_ff[i]) begin
               mem_ff[{page_base_ff, PAGE_W'(i)}] <= page_buf_ff[i];
            end
         end
      end
   end

   assign sda_o = sda_lvl_ff;
   assign sda_oe_o = sda_oe_ff;
   assign busy_o = lnk.busy;
   assign standby_o = lnk.standby;

   AST_IGNORE_IDLE: assert property (@(posedge scl_i) disable iff (!nrst_i)
      !in_frame && !start_now |=> state_ff == ST_IDLE)
      else $error("left idle without a start");
   AST_TYPE_NACK: assert property (@(posedge scl_i) disable iff (!nrst_i)
      (state_ff == ST_DEV) && byte_done && !type_ok |=> !ack_ff)
      else $error("foreign device type acknowledged");
   AST_STRAP_NACK: assert property (@(posedge scl_i) disable iff (!nrst_i)
      (state_ff == ST_DEV) && byte_done && !cs_ok |=> !ack_ff)
      else $error("strap mismatch acknowledged");
   AST_BUSY_NACK: assert property (@(posedge scl_i) disable iff (!nrst_i)
      (state_ff == ST_DEV) && byte_done && busy_s2_ff
      |=> !ack_ff ##1 state_ff == ST_IDLE)
      else $error("address acknowledged while programming");
   AST_READ_DIR: assert property (@(posedge scl_i) disable iff (!nrst_i)
      (state_ff == ST_DEV) && byte_done && dev_ok && rd_dir
      |=> ##1 state_ff == ST_RDAT)
      else $error("read direction not entered");
   AST_ACK_DRIVE: assert property (@(posedge scl_i) disable iff (!nrst_i)
      drive_ack |-> sda_oe_o)
      else $error("acknowledge not driven");
   AST_RELEASE: assert property (@(posedge scl_i) disable iff (!nrst_i)
      !(ack_slot && ack_ff) && (state_ff != ST_RDAT) |-> !sda_oe_o)
      else $error("data line held without cause");
   AST_ADDR_LOAD: assert property (@(posedge scl_i) disable iff (!nrst_i)
      (state_ff == ST_ALO) && byte_done
      |=> ptr_ff == {$past(addr_hi_ff), $past(rx_byte)})
      else $error("address pointer not loaded");
   AST_PAGE_WRAP: assert property (@(posedge scl_i) disable iff (!nrst_i)
      wr_take |=> (ptr_ff[ADDR_W-1:PAGE_W] ==
                   $past(ptr_ff[ADDR_W-1:PAGE_W])) &&
                  (ptr_ff[PAGE_W-1:0] ==
                   PAGE_W'($past(ptr_ff[PAGE_W-1:0]) + 1'b1)))
      else $error("page address step wrong");
   AST_WP_NACK: assert property (@(posedge scl_i) disable iff (!nrst_i)
      (state_ff == ST_WDAT) && byte_done && wp_s2_ff
      |=> !ack_ff && !wr_pend_ff)
      else $error("protected write accepted");
   AST_READ_STEP: assert property (@(posedge scl_i) disable iff (!nrst_i)
      load_rd |=> ptr_ff == ADDR_W'($past(ptr_ff) + 1'b1) &&
                  tx_ff == $past(rd_byte))
      else $error("sequential read step wrong");

   COV_READ_ACK: cover property (@(posedge scl_i) disable iff (!nrst_i)
      load_rd && (state_ff == ST_RDAT));
   COV_PAGE_ROLL: cover property (@(posedge scl_i) disable iff (!nrst_i)
      wr_take && (ptr_ff[PAGE_W-1:0] == {PAGE_W{1'b1}}));
   COV_BUSY_POLL: cover property (@(posedge scl_i) disable iff (!nrst_i)
      (state_ff == ST_DEV) && byte_done && busy_s2_ff);
endmodule

// [testbench/eepi_ctl_model.sv]
`timescale 1ns/100ps
module eepi_ctl_model (
   input wire logic sda_i,
   output logic scl_o,
   output logic sda_pull_o
);
   // Idle bus: clock parked high, data released
   initial begin
      scl_o = 1'b1;
      sda_pull_o = 1'b0;
   end
   task automatic drop();
      #40;
      scl_o = 1'b0;
   endtask
   // Data moves a step after the clock falls, never in the same time step
   task automatic start_c();
      #40;
      sda_pull_o = 1'b0;
      #40;
      scl_o = 1'b1;
      #40;
      sda_pull_o = 1'b1;
      #40;
      scl_o = 1'b0;
   endtask
   task automatic stop_c();
      #40;
      sda_pull_o = 1'b1;
      #40;
      scl_o = 1'b1;
      #40;
      sda_pull_o = 1'b0;
      #40;
   endtask
   // Data moves mid low phase, sampled mid high phase
   task automatic put_bit(input logic b, output logic s);
      #40;
      sda_pull_o = ~b;
      #40;
      scl_o = 1'b1;
      #40;
      s = sda_i;
      #40;
      scl_o = 1'b0;
   endtask
   task automatic wr_byte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         put_bit(b[i], s);
      end
      put_bit(1'b1, s);
      ack = ~s;
   endtask
   task automatic rd_byte(input logic ack_it, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         put_bit(1'b1, s);
         b[i] = s;
      end
      put_bit(~ack_it, s);
   endtask
   // Start only once data seen high with clock high
   task automatic recover();
      logic s;
      s = 1'b0;
      #40;
      sda_pull_o = 1'b0;
      for (int n = 0; n < 9 && !s; n++) begin
         #80;
         scl_o = 1'b1;
         #40;
         s = sda_i;
         if (!s) begin
            #40;
            scl_o = 1'b0;
         end
      end
      sda_pull_o = 1'b1;
      #40;
      scl_o = 1'b0;
      stop_c();
   endtask
endmodule

// [testbench/eepi_target_bench.sv]
`timescale 1ns/100ps
`define CHK(got, exp) \
   begin \
      num_checks++; \
      if ((got) !== (exp)) begin \
         err_total++; \
         $display("Error at %0t: got %0h expected %0h", $time, got, exp); \
      end \
   end
module eepi_target_bench
   import eepi_pkg::*;
;
   localparam int PROG_N = 200;
   localparam logic [2:0] STRAP = 3'h5;
   logic clk_i, nrst_i, wp_i, scl, ctl_pull, sda_w, ce;
   logic sda_o, sda_oe_o, busy_o, standby_o, ack;
   logic [2:0] strap;
   logic [7:0] rd;
   int err_total, num_checks;
   int busy_cnt = 0;
   // Pull-up wins unless someone pulls low
   assign sda_w = ~(ctl_pull | (sda_oe_o & ~sda_o));
   eepi_target #(.PROG_CYCLES(PROG_N)) dut (
      .clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce), .scl_i(scl),
      .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .wp_i(wp_i),
      .chip_select_strap_0_i(strap[0]), .chip_select_strap_1_i(strap[1]),
      .chip_select_strap_2_i(strap[2]), .busy_o(busy_o),
      .standby_o(standby_o)
   );
   eepi_ctl_model ctl (.sda_i(sda_w), .scl_o(scl), .sda_pull_o(ctl_pull));
   always #25 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      if (busy_o === 1'b1) busy_cnt <= busy_cnt + 1;
   end
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic dev(input logic rw, input logic e);
      ctl.start_c();
      ctl.wr_byte({DEV_MAIN, strap, rw}, ack);
      `CHK(ack, e)
   endtask
   task automatic bye();
      ctl.stop_c();
      repeat (12) @(posedge clk_i);
      `CHK(sda_oe_o, 1'b0)
   endtask
   task automatic point(input logic [15:0] a);
      dev(1'b0, 1'b1);
      ctl.wr_byte(a[15:8], ack);
      `CHK(ack, 1'b1)
      ctl.wr_byte(a[7:0], ack);
      `CHK(ack, 1'b1)
   endtask
   task automatic poll(input int base);
      int n;
      n = 0;
      do begin
         ctl.start_c();
         ctl.wr_byte({DEV_MAIN, strap, 1'b0}, ack);
         ctl.stop_c();
         repeat (10) @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 40);
      `CHK(ack, 1'b1)
      `CHK(busy_cnt - base, PROG_N)
      `CHK(standby_o, 1'b1)
   endtask
   task automatic prog();
      int base;
      base = busy_cnt;
      bye();
      `CHK(busy_o, 1'b1)
      `CHK(standby_o, 1'b0)
      dev(1'b0, 1'b0);
      ctl.stop_c();
      repeat (10) @(posedge clk_i);
      poll(base);
   endtask
   task automatic write_one(input logic [15:0] a, input logic [7:0] d);
      point(a);
      ctl.wr_byte(d, ack);
      `CHK(ack, 1'b1)
      prog();
   endtask
   task automatic read_seq(input logic [15:0] a, input logic [7:0] q[$]);
      point(a);
      dev(1'b1, 1'b1);
      foreach (q[i]) begin
         ctl.rd_byte(i < q.size() - 1, rd);
         `CHK(rd, q[i])
      end
      bye();
      `CHK(standby_o, 1'b1)
   endtask
   task automatic t_idle();
      `CHK(standby_o, 1'b1)
      `CHK(busy_o, 1'b0)
      ctl.drop();
      ctl.wr_byte({DEV_MAIN, strap, 1'b0}, ack);
      `CHK(ack, 1'b0)
      bye();
      $display("idle test done");
   endtask
   task automatic t_decode();
      for (int i = 0; i < 8; i++) begin
         ctl.start_c();
         ctl.wr_byte({DEV_MAIN, 3'(i), 1'b0}, ack);
         `CHK(ack, 3'(i) == STRAP)
         bye();
      end
      ctl.start_c();
      ctl.wr_byte({4'hb, strap, 1'b0}, ack);
      `CHK(ack, 1'b0)
      bye();
      @(posedge clk_i);
      #5 strap = 3'h0;
      dev(1'b1, 1'b1);
      ctl.rd_byte(1'b0, rd);
      `CHK(rd, ERASED)
      bye();
      @(posedge clk_i);
      #5 strap = STRAP;
      $display("decode test done");
   endtask
   task automatic t_write_read();
      write_one(16'h1234, 8'h5a);
      read_seq(16'h1233, '{ERASED});
      dev(1'b1, 1'b1);
      ctl.rd_byte(1'b1, rd);
      `CHK(rd, 8'h5a)
      ctl.rd_byte(1'b0, rd);
      `CHK(rd, ERASED)
      bye();
      $display("write read test done");
   endtask
   task automatic t_wp();
      @(posedge clk_i);
      #5 wp_i = 1'b1;
      point(16'h1234);
      ctl.wr_byte(8'h00, ack);
      `CHK(ack, 1'b0)
      bye();
      `CHK(busy_o, 1'b0)
      @(posedge clk_i);
      #5 wp_i = 1'b0;
      read_seq(16'h1234, '{8'h5a});
      $display("protect test done");
   endtask
   task automatic t_page();
      logic [7:0] exp[$];
      int k;
      point(16'h2178);
      for (int i = 0; i < 130; i++) begin
         ctl.wr_byte(8'(i), ack);
         `CHK(ack, 1'b1)
      end
      prog();
      for (int o = 0; o < 128; o++) begin
         k = (o - 'h78) & 'h7f;
         exp.push_back(8'(k < 2 ? k + 128 : k));
      end
      exp.push_back(ERASED);
      read_seq(16'h2100, exp);
      $display("page test done");
   endtask
   task automatic t_wrap();
      write_one(16'hffff, 8'ha5);
      write_one(16'h0000, 8'h3c);
      read_seq(16'hffff, '{8'ha5, 8'h3c});
      $display("wrap test done");
   endtask
   // Enable low must hold the programming start back until it returns
   task automatic t_freeze();
      int base;
      point(16'h0040);
      ctl.wr_byte(8'h77, ack);
      `CHK(ack, 1'b1)
      ctl.stop_c();
      @(posedge clk_i);
      #5 ce = 1'b0;
      base = busy_cnt;
      repeat (20) @(posedge clk_i);
      `CHK(busy_o, 1'b0)
      #5 ce = 1'b1;
      repeat (10) @(posedge clk_i);
      `CHK(busy_o, 1'b1)
      poll(base);
      read_seq(16'h0040, '{8'h77});
      $display("freeze test done");
   endtask
   task automatic t_recover();
      point(16'h2100);
      dev(1'b1, 1'b1);
      ctl.rd_byte(1'b1, rd);
      `CHK(rd, 8'h08)
      ctl.recover();
      repeat (12) @(posedge clk_i);
      `CHK(sda_oe_o, 1'b0)
      dev(1'b0, 1'b1);
      bye();
      $display("recover test done");
   endtask
   initial begin
      clk_i = 1'b0;
      nrst_i = 1'b0;
      wp_i = 1'b0;
      ce = 1'b1;
      strap = STRAP;
      err_total = 0;
      num_checks = 0;
      repeat (3) @(posedge clk_i);
      #5 nrst_i = 1'b1;
      repeat (4) @(posedge clk_i);
      t_idle();
      t_decode();
      t_write_read();
      t_wp();
      t_page();
      t_wrap();
      t_freeze();
      t_recover();
      tally_and_finish();
   end
   // Whole run needs well under a millisecond
   initial begin
      #3_000_000;
      err_total++;
      tally_and_finish();
   end
endmodule
